// File: shared/ssx_pkg.sv
package ssx_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam logic [6:0] DIR_A_SEL = 7'h05;
  localparam logic [6:0] DIR_B_SEL = 7'h06;
  localparam logic [6:0] DIR_C_SEL = 7'h07;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] DIR_RESET = 8'hFF;
  localparam logic [2:0] FLAGS_RESET = 3'h0;
  localparam logic DEST_ACC = 1'b0;

  typedef enum logic [2:0] {
    SSX_OP_NONE = 3'b000,
    SSX_OP_SUB = 3'b001,
    SSX_OP_SUBB = 3'b010,
    SSX_OP_SWAP = 3'b011,
    SSX_OP_DIR = 3'b100,
    SSX_OP_XORL = 3'b101,
    SSX_OP_XORF = 3'b110
  } ssx_op_t;

  typedef struct packed {
    logic valid;
    ssx_op_t op;
    logic [ADDR_W-1:0] addr;
    logic dest;
    logic [DATA_W-1:0] literal;
  } ssx_instr_t;

  typedef struct packed {
    logic carry;
    logic half_carry_flag;
    logic zero;
  } ssx_flags_t;

  typedef struct packed {
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } ssx_wr_t;
endpackage

// File: logic/ssx_dir_regs.sv
module ssx_dir_regs
  import ssx_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [1:0] sel,
  input wire logic [7:0] wdata,
  output logic [7:0] port_a_direction,
  output logic [7:0] port_b_direction,
  output logic [7:0] port_c_direction
);
  logic [7:0] a_d, b_d, c_d;

  always_comb
  begin
    a_d = port_a_direction;
    b_d = port_b_direction;
    c_d = port_c_direction;
    if (we)
    begin
      case (sel)
        2'h1: a_d = wdata;
        2'h2: b_d = wdata;
        2'h3: c_d = wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      port_a_direction <= DIR_RESET;
      port_b_direction <= DIR_RESET;
      port_c_direction <= DIR_RESET;
    end
    else
    begin
      port_a_direction <= a_d;
      port_b_direction <= b_d;
      port_c_direction <= c_d;
    end
  end
endmodule // ssx_dir_regs

// File: logic/ssx_execute.sv
module ssx_execute
  import ssx_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input ssx_pkg::ssx_instr_t instr,
  input wire logic [ssx_pkg::DATA_W-1:0] file_rdata,
  output ssx_pkg::ssx_wr_t file_wr,
  output logic [ssx_pkg::DATA_W-1:0] acc,
  output ssx_pkg::ssx_flags_t flags,
  output logic bad_operand,
  output logic [ssx_pkg::DATA_W-1:0] port_a_direction,
  output logic [ssx_pkg::DATA_W-1:0] port_b_direction,
  output logic [ssx_pkg::DATA_W-1:0] port_c_direction
);
  import ssx_pkg::*;

  // Register-operand ops that honour the destination select bit
  function automatic logic uses_dest(input ssx_op_t op);
    logic hit;
    hit = 1'b0;
    case (op)
      SSX_OP_SUB: hit = 1'b1;
      SSX_OP_SUBB: hit = 1'b1;
      SSX_OP_SWAP: hit = 1'b1;
      SSX_OP_XORF: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // Zero test shared by every op that touches the zero flag
  function automatic logic is_zero(input logic [DATA_W-1:0] value);
    return value == 8'h00;
  endfunction

  // Minuend minus subtrahend minus borrow; bit 8 is the borrow out
  function automatic logic [8:0] sub_borrow(
    input logic [7:0] minuend,
    input logic [7:0] subtrahend,
    input logic borrow
  );
    return {1'b0, minuend} - {1'b0, subtrahend} - {8'h00, borrow};
  endfunction

  // Zero-extended nibbles underflow into bit 8 exactly when the low nibble borrows
  function automatic logic nibble_borrow(
    input logic [3:0] minuend,
    input logic [3:0] subtrahend,
    input logic borrow
  );
    logic [8:0] full;
    full = sub_borrow({4'h0, minuend}, {4'h0, subtrahend}, borrow);
    return full[8];
  endfunction

  // Load-port-direction accepts operands 5, 6 and 7 only
  function automatic logic is_dir_operand(input logic [ADDR_W-1:0] operand);
    return operand == DIR_A_SEL || operand == DIR_B_SEL || operand == DIR_C_SEL;
  endfunction

  // Bank index for the direction registers, 0 when nothing is selected
  function automatic logic [1:0] dir_index(input logic [ADDR_W-1:0] operand);
    logic [1:0] idx;
    idx = 2'h0;
    if (operand == DIR_A_SEL)
      idx = 2'h1;
    else if (operand == DIR_B_SEL)
      idx = 2'h2;
    else if (operand == DIR_C_SEL)
      idx = 2'h3;
    return idx;
  endfunction

  logic rst_meta_q, rst_n_q;
  logic [7:0] acc_q, acc_d;
  ssx_flags_t flags_q, flags_d;
  ssx_wr_t wr_q, wr_d;
  logic bad_q, bad_d;
  logic dir_we;
  logic [1:0] dir_sel;
  logic [7:0] result;
  logic [8:0] diff;
  logic borrow_in;

  // Reset release synchroniser
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // Next-state decode, one instruction per cycle
  always_comb
  begin
    acc_d = acc_q;
    flags_d = flags_q;
    wr_d = '0;
    bad_d = 1'b0;
    dir_we = 1'b0;
    dir_sel = 2'h0;
    result = 8'h00;
    borrow_in = 1'b0;
    diff = 9'h000;
    if (instr.valid)
    begin
      case (instr.op)
        SSX_OP_SUB, SSX_OP_SUBB:
        begin
          // Borrow is the inverted carry
          borrow_in = (instr.op == SSX_OP_SUBB) ? ~flags_q.carry : 1'b0;
          diff = sub_borrow(file_rdata, acc_q, borrow_in);
          result = diff[7:0];
          flags_d.carry = ~diff[8];
          flags_d.half_carry_flag = ~nibble_borrow(file_rdata[3:0], acc_q[3:0],
            borrow_in);
          flags_d.zero = is_zero(result);
        end
        SSX_OP_SWAP: result = {file_rdata[3:0], file_rdata[7:4]};
        SSX_OP_XORF:
        begin
          result = acc_q ^ file_rdata;
          flags_d.zero = is_zero(result);
        end
        SSX_OP_XORL:
        begin
          result = acc_q ^ instr.literal;
          flags_d.zero = is_zero(result);
          acc_d = result;
        end
        SSX_OP_DIR:
        begin
          // Operands outside 5..7 are refused and flagged
          if (is_dir_operand(instr.addr))
          begin
            dir_we = 1'b1;
            dir_sel = dir_index(instr.addr);
          end
          else
            bad_d = 1'b1;
        end
        default: ;
      endcase
      // Destination steering for register-operand ops
      if (uses_dest(instr.op))
      begin
        if (instr.dest == DEST_ACC)
          acc_d = result;
        else
        begin
          wr_d.we = 1'b1;
          wr_d.addr = instr.addr;
          wr_d.data = result;
        end
      end
    end
  end

  // Architectural state, committed in the same cycle the op is taken
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      acc_q <= ACC_RESET;
      flags_q <= FLAGS_RESET;
    end
    else
    begin
      acc_q <= acc_d;
      flags_q <= flags_d;
    end
  end

  // File write port, a one-cycle pulse per register-destination op
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      wr_q <= '0;
    end
    else
    begin
      wr_q <= wr_d;
    end
  end

  // Refused-operand pulse
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      bad_q <= 1'b0;
    end
    else
    begin
      bad_q <= bad_d;
    end
  end

  ssx_dir_regs u_dir (
    .clk(clk),
    .rst_n(rst_n_q),
    .we(dir_we),
    .sel(dir_sel),
    .wdata(acc_q),
    .port_a_direction(port_a_direction),
    .port_b_direction(port_b_direction),
    .port_c_direction(port_c_direction)
  );

  assign acc = acc_q;
  assign flags = flags_q;
  assign file_wr = wr_q;
  assign bad_operand = bad_q;
endmodule // ssx_execute

// File: bench/ssx_execute_asserts.sv
module ssx_execute_asserts
  import ssx_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input ssx_pkg::ssx_instr_t instr,
  input wire logic [ssx_pkg::DATA_W-1:0] file_rdata,
  input ssx_pkg::ssx_wr_t file_wr,
  input wire logic [ssx_pkg::DATA_W-1:0] acc,
  input ssx_pkg::ssx_flags_t flags,
  input wire logic bad_operand,
  input wire logic [ssx_pkg::DATA_W-1:0] port_b_direction
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence go(ssx_op_t o);
    instr.valid && instr.op == o;
  endsequence
  sub_to_reg_a: assert property (go(SSX_OP_SUB) ##0 instr.dest |=> file_wr.we &&
    file_wr.data == $past(file_rdata) - $past(acc)) else $error("sub write");
  sub_flags_a: assert property (go(SSX_OP_SUB) |=> flags.carry == ($past(acc) <=
    $past(file_rdata))) else $error("sub carry");
  subb_acc_a: assert property (go(SSX_OP_SUBB) ##0 !instr.dest |=> acc ==
    $past(file_rdata) - $past(acc) - !$past(flags.carry)) else $error("subb acc");
  swap_acc_a: assert property (go(SSX_OP_SWAP) ##0 !instr.dest |=> $stable(flags) &&
    acc == {$past(file_rdata[3:0]), $past(file_rdata[7:4])}) else $error("swap");
  dir_load_a: assert property (go(SSX_OP_DIR) ##0 instr.addr == DIR_B_SEL |=>
    port_b_direction == $past(acc) && $stable(flags)) else $error("dir load");
  dir_refuse_a: assert property (go(SSX_OP_DIR) ##0
    !(instr.addr inside {[DIR_A_SEL:DIR_C_SEL]}) |=> bad_operand && $stable(port_b_direction))
    else $error("dir refuse");
  xorl_acc_a: assert property (go(SSX_OP_XORL) |=> acc == ($past(acc) ^
    $past(instr.literal)) && $stable(flags.carry)) else $error("xorl");
  xorf_zero_a: assert property (go(SSX_OP_XORF) |=> flags.zero ==
    (($past(acc) ^ $past(file_rdata)) == 8'h00)) else $error("xorf zero");
endmodule // ssx_execute_asserts
bind ssx_execute ssx_execute_asserts i_ssx_execute_asserts (.clk(clk), .reset_n(reset_n),
  .instr(instr), .file_rdata(file_rdata), .file_wr(file_wr), .acc(acc), .flags(flags),
  .bad_operand(bad_operand), .port_b_direction(port_b_direction));

// File: bench/ssx_file_mem.sv
module ssx_file_mem
  import ssx_pkg::*;
(
  input wire logic clk,
  input wire logic [6:0] addr,
  input ssx_pkg::ssx_wr_t wr,
  output logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [128];
  initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 8'h25);
  always @(posedge clk) if (wr.we) mem[wr.addr] <= wr.data;
  // Forward a write in flight to a back-to-back read
  assign rdata = (wr.we && wr.addr == addr) ? wr.data : mem[addr];
endmodule // ssx_file_mem

// File: bench/test_subtract_swap_xor_execute.sv
module test_subtract_swap_xor_execute
  import ssx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  ssx_instr_t ins = '0;
  ssx_wr_t fw;
  ssx_flags_t flg, fl;
  logic [7:0] rd, acc, pa, pb, pc, am;
  logic bad;
  logic [7:0] fm [128];
  logic [7:0] dm [3];
  int fail_count = 0;
  int n_checks = 0;
  always #20 clk = ~clk;
  ssx_execute i_ssx_execute (.clk(clk), .reset_n(reset_n), .instr(ins), .file_rdata(rd),
    .file_wr(fw), .acc(acc), .flags(flg), .bad_operand(bad), .port_a_direction(pa),
    .port_b_direction(pb), .port_c_direction(pc));
  ssx_file_mem i_ssx_file_mem (.clk(clk), .addr(ins.addr), .wr(fw), .rdata(rd));
  task chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("unexpected %s: expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask
  task give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task ex(input ssx_op_t op, input logic [6:0] a, input logic d, input logic [7:0] k);
    logic [8:0] t;
    logic [4:0] n;
    logic [7:0] f, r;
    logic b, w, x;
    f = fm[a];
    b = (op == SSX_OP_SUBB) && !fl.carry;
    w = d && op inside {SSX_OP_SUB, SSX_OP_SUBB, SSX_OP_SWAP, SSX_OP_XORF};
    x = op == SSX_OP_DIR && !(a inside {[5:7]});
    ins = '{1'b1, op, a, d, k};
    t = {1'b0, f} - {1'b0, am} - 9'(b);
    n = {1'b0, f[3:0]} - {1'b0, am[3:0]} - 5'(b);
    r = (op == SSX_OP_XORL) ? am ^ k : (op == SSX_OP_XORF) ? am ^ f : t[7:0];
    if (op == SSX_OP_SWAP) r = {f[3:0], f[7:4]};
    if (op inside {SSX_OP_SUB, SSX_OP_SUBB}) fl = '{!t[8], !n[4], r == 8'h00};
    if (op inside {SSX_OP_XORL, SSX_OP_XORF}) fl.zero = (r == 8'h00);
    if (op == SSX_OP_DIR && !x) dm[a - 7'h05] = am;
    if (w) fm[a] = r;
    else if (op != SSX_OP_DIR && op != SSX_OP_NONE) am = r;
    @(posedge clk);
    #1;
    chk("acc", 24'(am), 24'(acc));
    chk("flags", 24'(fl), 24'(flg));
    chk("we", 24'(w), 24'(fw.we));
    if (w) chk("wdata", 24'(r), 24'(fw.data));
    if (w) chk("waddr", 24'(a), 24'(fw.addr));
    chk("dir", {dm[0], dm[1], dm[2]}, {pa, pb, pc});
    chk("bad", 24'(x), 24'(bad));
  endtask
  task t_sub();
    ex(SSX_OP_XORL, 7'h00, 1'b0, 8'h3C);
    ex(SSX_OP_SUB, 7'h01, 1'b1, 8'h00);
    ex(SSX_OP_XORL, 7'h00, 1'b0, am ^ fm[3]);
    ex(SSX_OP_SUB, 7'h03, 1'b0, 8'h00);
    $display("sub done");
  endtask
  task t_subb();
    ex(SSX_OP_SUBB, 7'h7F, 1'b1, 8'h00);
    ex(SSX_OP_XORL, 7'h00, 1'b0, 8'hF0);
    ex(SSX_OP_SUBB, 7'h02, 1'b0, 8'h00);
    ex(SSX_OP_SUBB, 7'h01, 1'b0, 8'h00);
    $display("subb done");
  endtask
  task t_swap();
    ex(SSX_OP_SWAP, 7'h01, 1'b0, 8'h00);
    ex(SSX_OP_SWAP, 7'h7F, 1'b1, 8'h00);
    $display("swap done");
  endtask
  task t_dir();
    for (int i = 4; i <= 8; i++)
    begin
      ex(SSX_OP_XORL, 7'h00, 1'b0, 8'(i * 8'h11));
      ex(SSX_OP_DIR, 7'(i), 1'b0, 8'h00);
    end
    $display("dir done");
  endtask
  task t_xor();
    ex(SSX_OP_XORL, 7'h05, 1'b1, am);
    ex(SSX_OP_XORF, 7'h03, 1'b1, 8'h00);
    ex(SSX_OP_XORF, 7'h03, 1'b0, 8'h00);
    ex(SSX_OP_NONE, 7'h03, 1'b1, 8'h00);
    $display("xor done");
  endtask
  initial
  begin
    for (int i = 0; i < 128; i++) fm[i] = 8'(i * 8'h25);
    dm = '{DIR_RESET, DIR_RESET, DIR_RESET};
    am = ACC_RESET;
    fl = FLAGS_RESET;
    repeat (4) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    t_sub();
    t_subb();
    t_swap();
    t_dir();
    t_xor();
    ins.valid = 1'b0;
    give_verdict();
  end
endmodule // test_subtract_swap_xor_execute
